// ==== src/pim_pkg.sv ====
package pim_pkg;

  localparam int PIM_NCH = 8;
  localparam int PIM_NPIN = 32;
  localparam int PIM_SELW = 5;
  localparam int PIM_AW = 6;

  // register word offsets (byte address = 4 * index)
  localparam logic [PIM_AW-1:0] PIM_IDX_PINSEL0 = 6'h00;
  localparam logic [PIM_AW-1:0] PIM_IDX_PINSEL1 = 6'h01;
  localparam logic [PIM_AW-1:0] PIM_IDX_MODE = 6'h02;
  localparam logic [PIM_AW-1:0] PIM_IDX_RISE_EN = 6'h03;
  localparam logic [PIM_AW-1:0] PIM_IDX_FALL_EN = 6'h04;
  localparam logic [PIM_AW-1:0] PIM_IDX_LVL_POL = 6'h05;
  localparam logic [PIM_AW-1:0] PIM_IDX_STATUS = 6'h06;
  localparam logic [PIM_AW-1:0] PIM_IDX_CLEAR = 6'h07;
  localparam logic [PIM_AW-1:0] PIM_IDX_INT_EN = 6'h08;
  localparam logic [PIM_AW-1:0] PIM_IDX_PM_CTRL = 6'h09;
  localparam logic [PIM_AW-1:0] PIM_IDX_PM_TERM0 = 6'h0A;
  localparam logic [PIM_AW-1:0] PIM_IDX_PIN_STATE = 6'h12;

  localparam logic [31:0] PIM_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] PIM_UNMAPPED_WORD = 32'h0000_0000;

  // term field codes, 3 bits per input in each product-term word
  localparam logic [2:0] PIM_TERM_DONT_CARE = 3'h0;
  localparam logic [2:0] PIM_TERM_HIGH = 3'h1;
  localparam logic [2:0] PIM_TERM_LOW = 3'h2;
  localparam logic [2:0] PIM_TERM_RISE = 3'h3;
  localparam logic [2:0] PIM_TERM_FALL = 3'h4;
  localparam logic [2:0] PIM_TERM_ANY_EDGE = 3'h5;

  typedef struct packed {
    logic [PIM_AW-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } pim_bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } pim_bus_rsp_t;

  typedef struct packed {
    logic [PIM_NCH-1:0] level;
    logic [PIM_NCH-1:0] rise;
    logic [PIM_NCH-1:0] fall;
  } pim_pin_ev_t;

endpackage

// ==== src/pim_pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module pim_pin_sync
  import pim_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [PIM_NPIN-1:0] i_pins,
  input wire logic [PIM_NCH*PIM_SELW-1:0] i_sel,
  output pim_pin_ev_t o_ev
);

  typedef struct packed {
    logic [PIM_NPIN-1:0] meta;
    logic [PIM_NPIN-1:0] sync;
    logic [PIM_NCH-1:0] prev;
    logic primed;
  } pim_sync_state_t;

  pim_sync_state_t state_reg;
  pim_sync_state_t state_next;
  logic [PIM_NCH-1:0] cur;

  // any pin feeds any channel, whatever its pad function
  genvar g;
  generate
    for (g = 0; g < PIM_NCH; g++)
    begin : g_sel
      assign cur[g] = state_reg.sync[i_sel[g*PIM_SELW +: PIM_SELW]];
    end
  endgenerate

  always_comb
  begin
    state_next = state_reg;
    state_next.meta = i_pins;
    state_next.sync = state_reg.meta;
    state_next.prev = cur;
    state_next.primed = 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // no edge reported until a previous sample exists
  assign o_ev.level = cur;
  assign o_ev.rise = state_reg.primed ? (cur & ~state_reg.prev) : '0;
  assign o_ev.fall = state_reg.primed ? (~cur & state_reg.prev) : '0;

endmodule // pim_pin_sync
`default_nettype wire

// ==== src/pim_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module pim_top
  import pim_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [PIM_NPIN-1:0] i_pins,
  input wire logic [PIM_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [PIM_NCH-1:0] o_irq,
  output logic o_irq_any,
  output logic o_wake
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [PIM_NCH*PIM_SELW-1:0] pinsel;
    logic [PIM_NCH-1:0] mode_level;
    logic [PIM_NCH-1:0] rise_en;
    logic [PIM_NCH-1:0] fall_en;
    logic [PIM_NCH-1:0] lvl_pol;
    logic [PIM_NCH-1:0] status;
    logic [PIM_NCH-1:0] int_en;
    logic pm_on;
    logic [PIM_NCH-1:0] pm_term_used;
    logic [PIM_NCH*PIM_NCH*3-1:0] pm_terms;
    logic [PIM_NCH-1:0] term_prev;
  } pim_state_t;

  pim_state_t state_reg;
  pim_state_t state_next;
  pim_bus_req_t req;
  pim_pin_ev_t ev;
  logic [PIM_NCH-1:0] src_hit;
  logic [PIM_NCH-1:0] term_now;
  logic [PIM_NCH-1:0] term_rise;
  logic [PIM_NCH-1:0] event_set;
  logic [PIM_NCH-1:0] clr_mask;
  logic [31:0] rd_mux;

  assign req.address = i_avs_address;
  assign req.read = i_avs_read;
  assign req.write = i_avs_write;
  assign req.writedata = i_avs_writedata;

  pim_pin_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_pins(i_pins),
    .i_sel(state_reg.pinsel),
    .o_ev(ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin interrupt sources, one per channel
  genvar c;
  generate
    for (c = 0; c < PIM_NCH; c++)
    begin : g_ch
      logic [PIM_NCH-1:0] lit;
      logic [PIM_NCH*3-1:0] tw;
      assign src_hit[c] = state_reg.mode_level[c]
        ? (ev.level[c] ~^ state_reg.lvl_pol[c])
        : ((ev.rise[c] & state_reg.rise_en[c]) | (ev.fall[c] & state_reg.fall_en[c]));
      assign tw = state_reg.pm_terms[c*PIM_NCH*3 +: PIM_NCH*3];
      // term c: AND over inputs of each input's test
      for (genvar k = 0; k < PIM_NCH; k++)
      begin : g_in
        always_comb
        begin
          unique case (tw[k*3 +: 3])
            PIM_TERM_DONT_CARE: lit[k] = 1'b1;
            PIM_TERM_HIGH: lit[k] = ev.level[k];
            PIM_TERM_LOW: lit[k] = ~ev.level[k];
            PIM_TERM_RISE: lit[k] = ev.rise[k];
            PIM_TERM_FALL: lit[k] = ev.fall[k];
            PIM_TERM_ANY_EDGE: lit[k] = ev.rise[k] | ev.fall[k];
            default: lit[k] = 1'b0;
          endcase
        end
      end
      assign term_now[c] = state_reg.pm_term_used[c] & (&lit);
    end
  endgenerate

  // a term fires once as it becomes true, not for as long as it holds
  assign term_rise = term_now & ~state_reg.term_prev;
  assign event_set = state_reg.pm_on ? term_rise : src_hit;

  ////////////////////////////////////////////////////////////////////////////
  // register read mux
  always_comb
  begin
    rd_mux = PIM_UNMAPPED_WORD;
    if (req.address == PIM_IDX_PINSEL0)
      rd_mux = {12'h000, state_reg.pinsel[19:0]};
    else if (req.address == PIM_IDX_PINSEL1)
      rd_mux = {12'h000, state_reg.pinsel[39:20]};
    else if (req.address == PIM_IDX_MODE)
      rd_mux = {24'h00_0000, state_reg.mode_level};
    else if (req.address == PIM_IDX_RISE_EN)
      rd_mux = {24'h00_0000, state_reg.rise_en};
    else if (req.address == PIM_IDX_FALL_EN)
      rd_mux = {24'h00_0000, state_reg.fall_en};
    else if (req.address == PIM_IDX_LVL_POL)
      rd_mux = {24'h00_0000, state_reg.lvl_pol};
    else if (req.address == PIM_IDX_STATUS)
      rd_mux = {24'h00_0000, state_reg.status};
    else if (req.address == PIM_IDX_INT_EN)
      rd_mux = {24'h00_0000, state_reg.int_en};
    else if (req.address == PIM_IDX_PM_CTRL)
      rd_mux = {15'h0000, state_reg.pm_on, 8'h00, state_reg.pm_term_used};
    else if (req.address == PIM_IDX_PIN_STATE)
      rd_mux = {8'h00, ev.fall, ev.rise, ev.level};
    else if (req.address >= PIM_IDX_PM_TERM0 && req.address < PIM_IDX_PIN_STATE)
      rd_mux = {8'h00, state_reg.pm_terms[(req.address - PIM_IDX_PM_TERM0) * 24 +: 24]};
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    clr_mask = '0;
    state_next.term_prev = term_now;
    if (req.write)
    begin
      if (req.address == PIM_IDX_PINSEL0)
        state_next.pinsel[19:0] = req.writedata[19:0];
      else if (req.address == PIM_IDX_PINSEL1)
        state_next.pinsel[39:20] = req.writedata[19:0];
      else if (req.address == PIM_IDX_MODE)
        state_next.mode_level = req.writedata[7:0];
      else if (req.address == PIM_IDX_RISE_EN)
        state_next.rise_en = req.writedata[7:0];
      else if (req.address == PIM_IDX_FALL_EN)
        state_next.fall_en = req.writedata[7:0];
      else if (req.address == PIM_IDX_LVL_POL)
        state_next.lvl_pol = req.writedata[7:0];
      else if (req.address == PIM_IDX_CLEAR)
        clr_mask = req.writedata[7:0];
      else if (req.address == PIM_IDX_INT_EN)
        state_next.int_en = req.writedata[7:0];
      else if (req.address == PIM_IDX_PM_CTRL)
      begin
        state_next.pm_on = req.writedata[16];
        state_next.pm_term_used = req.writedata[7:0];
      end
      else if (req.address >= PIM_IDX_PM_TERM0 && req.address < PIM_IDX_PIN_STATE)
        state_next.pm_terms[(req.address - PIM_IDX_PM_TERM0) * 24 +: 24] = req.writedata[23:0];
    end
    // level sources re-set while active; set wins over clear
    state_next.status = (state_reg.status & ~clr_mask) | event_set;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_avs_waitrequest = 1'b0;
  // zero-wait read: data must stand at the accepting edge, so it is a mux of registers
  assign o_avs_readdata = rd_mux;
  assign o_irq = state_reg.status & state_reg.int_en;
  assign o_irq_any = |o_irq;
  // wake stays up regardless of enables so any pending source can wake
  assign o_wake = |state_reg.status;

  ////////////////////////////////////////////////////////////////////////////
  chk_zero_wait: assert property (@(posedge i_clk_sys) disable iff (i_srst) !o_avs_waitrequest)
    else $error("waitrequest raised");
  chk_edge_set: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!state_reg.pm_on && !state_reg.mode_level[0] && state_reg.rise_en[0] && ev.rise[0]) |=> state_reg.status[0])
    else $error("rising edge not latched");
  chk_level_set: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!state_reg.pm_on && state_reg.mode_level[1] && (ev.level[1] == state_reg.lvl_pol[1])) |=> state_reg.status[1])
    else $error("level source not latched");
  chk_set_wins: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (event_set[2] && req.write && req.address == PIM_IDX_CLEAR && req.writedata[2]) |=> state_reg.status[2])
    else $error("event lost to clear");
  chk_irq_line: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (state_reg.status[3] && state_reg.int_en[3]) |-> o_irq[3] && (o_irq[2] == (state_reg.status[2] && state_reg.int_en[2])))
    else $error("irq line mismatch");
  chk_term_fire: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (state_reg.pm_on && term_now[0] && !state_reg.term_prev[0]) |=> state_reg.status[0])
    else $error("term did not raise its line");
  chk_wake_out: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    event_set[4] |=> o_wake)
    else $error("no wake on pending");
  chk_fall_set: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!state_reg.pm_on && !state_reg.mode_level[2] && state_reg.fall_en[2] && ev.fall[2]) |=> state_reg.status[2])
    else $error("falling edge not latched");
  chk_clear_bit: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (req.write && req.address == PIM_IDX_CLEAR && req.writedata[6] && !event_set[6]) |=> !state_reg.status[6])
    else $error("status bit not cleared");
  chk_pm_masks: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (state_reg.pm_on && !term_rise[3] && !state_reg.status[3]) |=> !state_reg.status[3])
    else $error("pin source set in pattern mode");
  chk_read_status: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (req.read && req.address == PIM_IDX_STATUS) |-> (o_avs_readdata == {24'h00_0000, state_reg.status}))
    else $error("status read data wrong");
  chk_pin_edge: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (ev.rise[0] |-> (ev.level[0] && !$past(ev.level[0]))))
    else $error("edge without level change");
  chk_read_data: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (req.read && req.address == PIM_IDX_INT_EN) |-> (o_avs_readdata == {24'h00_0000, state_reg.int_en}))
    else $error("read data wrong");

endmodule // pim_top
`default_nettype wire

// ==== verif/pim_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module pim_far_model
  import pim_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [PIM_NCH-1:0] i_irq,
  output logic [PIM_NPIN-1:0] o_pins,
  output logic [PIM_NCH-1:0] o_taken
);
  // pads are push-pull levels, never released, so no floating state here
  initial o_pins = '0;

  task automatic set_pin(input logic [PIM_SELW-1:0] p, input logic v);
    o_pins[p] <= v;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // core side samples each request line on its own, no merging
  always_ff @(posedge i_clk_sys)
  begin
    o_taken <= i_irq;
  end
endmodule // pim_far_model
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench
  import pim_pkg::*;
;
  typedef struct packed {
    logic [2:0] ch; logic [4:0] pin; logic lvl; logic rise; logic fall; logic pol; logic v0; logic v1; logic hit;
  } pim_row_t;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic [PIM_NPIN-1:0] pins;
  logic [PIM_AW-1:0] address = '0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wdata = '0;
  logic [31:0] readdata, q;
  logic waitreq, irq_any, wake;
  logic [PIM_NCH-1:0] irq;
  logic [PIM_NCH-1:0] taken;
  logic [31:0] w [6];
  logic [7:0] hit;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  pim_row_t rows [8] = '{
    '{3'h0, 5'h03, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1},
    '{3'h1, 5'h1F, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0},
    '{3'h2, 5'h11, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
    '{3'h3, 5'h00, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
    '{3'h4, 5'h08, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1},
    '{3'h5, 5'h14, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1},
    '{3'h6, 5'h0C, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0},
    '{3'h7, 5'h05, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0}};

  pim_top i_dut (.i_clk_sys(clk_sys), .i_srst(srst), .i_pins(pins), .i_avs_address(address),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(readdata),
    .o_avs_waitrequest(waitreq), .o_irq(irq), .o_irq_any(irq_any), .o_wake(wake));
  pim_far_model i_far (.i_clk_sys(clk_sys), .i_irq(irq), .o_pins(pins), .o_taken(taken));

  always #4 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read data taken at the accepting edge; one idle edge before the next request
  task automatic bus(input logic is_wr, input logic [PIM_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    wdata <= d;
    wr <= is_wr;
    rd <= ~is_wr;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (waitreq !== 1'h0 && n < 50);
    q = readdata;
    chk("bus cycles", 32'h0000_0001, 32'(n));
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
    chk("outputs after reset", 32'h0000_0000, 32'({irq_any, wake, irq}));
    bus(1'h0, PIM_IDX_STATUS, 32'h0000_0000);
    chk("status after reset", 32'h0000_0000, q);
    for (int k = 0; k < 6; k++) w[k] = '0;
    hit = '0;
    foreach (rows[i])
    begin
      if (rows[i].ch < 4) w[0][5*rows[i].ch +: 5] = rows[i].pin;
      else w[1][5*(rows[i].ch-4) +: 5] = rows[i].pin;
      w[2][rows[i].ch] = rows[i].lvl;
      w[3][rows[i].ch] = rows[i].rise;
      w[4][rows[i].ch] = rows[i].fall;
      w[5][rows[i].ch] = rows[i].pol;
      hit[rows[i].ch] = rows[i].hit;
      i_far.set_pin(rows[i].pin, rows[i].v0);
    end
    for (int k = 0; k < 6; k++) bus(1'h1, PIM_AW'(k), w[k]);
    for (int k = 0; k < 6; k++)
    begin
      bus(1'h0, PIM_AW'(k), 32'h0000_0000);
      chk("config readback", w[k], q);
    end
    bus(1'h1, PIM_IDX_INT_EN, 32'h0000_00FF);
    settle();
    bus(1'h1, PIM_IDX_CLEAR, 32'h0000_00FF);
    foreach (rows[i]) i_far.set_pin(rows[i].pin, rows[i].v1);
    settle();
    bus(1'h0, PIM_IDX_STATUS, 32'h0000_0000);
    foreach (rows[i])
    begin
      chk("status bit", 32'(hit[rows[i].ch]), 32'(q[rows[i].ch]));
      chk("irq line", 32'(hit[rows[i].ch]), 32'(irq[rows[i].ch]));
      chk("taken line", 32'(hit[rows[i].ch]), 32'(taken[rows[i].ch]));
    end
    chk("irq vector", 32'(hit), 32'(irq));
    // hand-written cases: masking, clearing, read-only and unmapped places
    bus(1'h1, PIM_IDX_INT_EN, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    chk("masked irq", 32'h0000_0000, 32'({irq_any, irq}));
    chk("wake", 32'h0000_0001, 32'(wake));
    bus(1'h1, PIM_IDX_CLEAR, 32'h0000_0001);
    bus(1'h0, PIM_IDX_STATUS, 32'h0000_0000);
    chk("clear one", 32'(hit & 8'hFE), q);
    bus(1'h1, PIM_IDX_STATUS, 32'h0000_00FF);
    bus(1'h0, PIM_IDX_STATUS, 32'h0000_0000);
    chk("status read only", 32'(hit & 8'hFE), q);
    bus(1'h0, 6'h3F, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    bus(1'h1, PIM_IDX_CLEAR, 32'h0000_00FF);
    bus(1'h0, PIM_IDX_STATUS, 32'h0000_0000);
    chk("level holds", 32'h0000_0030, q);
    bus(1'h1, PIM_IDX_INT_EN, 32'h0000_00FF);
    repeat (2) @(posedge clk_sys);
    chk("irq reenabled", 32'h0000_0130, 32'({irq_any, irq}));
    // pattern: term0 = in0 high and in1 rising, term1 = in2 low
    i_far.set_pin(5'h03, 1'h1);
    i_far.set_pin(5'h1F, 1'h0);
    i_far.set_pin(5'h11, 1'h1);
    bus(1'h1, PIM_IDX_PM_TERM0, 32'({PIM_TERM_RISE, PIM_TERM_HIGH}));
    bus(1'h1, 6'h0B, 32'({PIM_TERM_LOW, 6'h00}));
    bus(1'h1, PIM_IDX_PM_CTRL, 32'h0001_0003);
    settle();
    bus(1'h1, PIM_IDX_CLEAR, 32'h0000_00FF);
    bus(1'h0, PIM_IDX_STATUS, 32'h0000_0000);
    chk("pattern idle", 32'h0000_0000, q);
    i_far.set_pin(5'h1F, 1'h1);
    settle();
    bus(1'h0, PIM_IDX_STATUS, 32'h0000_0000);
    chk("term0", 32'h0000_0001, q);
    i_far.set_pin(5'h11, 1'h0);
    settle();
    bus(1'h0, PIM_IDX_STATUS, 32'h0000_0000);
    chk("term1", 32'h0000_0003, q);
    // term2 = in0 falling, term3 = in1 any edge
    bus(1'h1, 6'h0C, 32'(PIM_TERM_FALL));
    bus(1'h1, 6'h0D, 32'({PIM_TERM_ANY_EDGE, 3'h0}));
    bus(1'h1, PIM_IDX_PM_CTRL, 32'h0001_000F);
    i_far.set_pin(5'h03, 1'h0);
    i_far.set_pin(5'h1F, 1'h0);
    settle();
    bus(1'h0, PIM_IDX_STATUS, 32'h0000_0000);
    chk("terms two and three", 32'h0000_000F, q);
    bus(1'h0, PIM_IDX_PIN_STATE, 32'h0000_0000);
    chk("pin state", 32'h0000_0050, q);
    // second reset in mid-run with pins still active
    srst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
    chk("outputs after rerun", 32'h0000_0000, 32'({irq_any, wake, irq}));
    bus(1'h0, PIM_IDX_STATUS, 32'h0000_0000);
    chk("status after rerun", 32'h0000_0000, q);
    final_report();
  end
endmodule // testbench
`default_nettype wire
